// *** tdm_pkg.sv ***
// package for the transfer descriptor map register bank
package tdm_pkg;
    // register offsets (byte addresses)
    localparam logic [11:0] TDM_ISO_DONE_OFS = 12'h130;
    localparam logic [11:0] TDM_ISO_SKIP_OFS = 12'h134;
    localparam logic [11:0] TDM_ISO_LAST_OFS = 12'h138;
    localparam logic [11:0] TDM_INT_DONE_OFS = 12'h140;
    // reset values
    localparam logic [31:0] TDM_DONE_RST = 32'h0000_0000;
    localparam logic [31:0] TDM_SKIP_RST = 32'hffff_ffff;
    localparam logic [31:0] TDM_LAST_RST = 32'h0000_0000;
    // port status field position
    localparam int TDM_CCS_BIT = 0;
    localparam int TDM_NUM_DESC = 32;

    // processor bus request
    typedef struct packed {
        logic cs;
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } tdm_bus_req_t;

    // scheduler visit reported by the scan unit
    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic wrap;
    } tdm_visit_t;

    typedef enum logic [1:0] {
        TDM_IDLE = 2'b00,
        TDM_SCAN = 2'b01,
        TDM_HOLD = 2'b10
    } tdm_scan_state_t;
endpackage

// *** tdm_done_map.sv ***
// sticky done bitmap, set on completion, cleared by read
`timescale 1ns/1ps
`default_nettype none
module tdm_done_map
    import tdm_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // events
    input wire logic [WIDTH-1:0] complete,
    input wire logic read_clear,
    // state
    output logic [WIDTH-1:0] map
);
    logic [WIDTH-1:0] map_reg;
    logic [WIDTH-1:0] map_next;

    initial begin
        if (WIDTH < 1 || WIDTH > 32) $error("tdm_done_map: WIDTH out of range");
    end

    // clear the bits just read, but a fresh completion wins
    always_comb begin
        map_next = map_reg;
        if (read_clear) begin
            map_next = '0;
        end
        map_next = map_next | complete;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            map_reg <= WIDTH'(TDM_DONE_RST);
        end else if (clk_en) begin
            map_reg <= map_next;
        end
    end

    assign map = map_reg;

    a_done_set_survives: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && (|complete) |=> ((map_reg & $past(complete)) == $past(complete)))
        else $error("completion lost in done map");
    a_done_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && read_clear && complete == '0 |=> map_reg == '0)
        else $error("done map not cleared by read");
endmodule
`default_nettype wire

// *** tdm_scan.sv ***
// isochronous descriptor scan order with skip and last marker
`timescale 1ns/1ps
`default_nettype none
module tdm_scan
    import tdm_pkg::*;
#(
    parameter int NUM = 32
) (
    // clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // steering maps and descriptor state
    input wire logic [NUM-1:0] skip_map,
    input wire logic [NUM-1:0] last_map,
    input wire logic [NUM-1:0] valid_map,
    input wire logic advance,
    // result
    output var tdm_visit_t visit
);
    logic [4:0] pos_reg;
    logic [4:0] pos_next;
    tdm_scan_state_t st_reg;
    tdm_scan_state_t st_next;
    logic is_last;
    logic take;

    initial begin
        if (NUM != TDM_NUM_DESC) $error("tdm_scan: NUM must be 32");
    end

    // a skipped slot is never acted on, even when valid; next pointers are ignored
    assign take = valid_map[pos_reg] && !skip_map[pos_reg];
    // no last bit set means the whole table is scanned
    assign is_last = last_map[pos_reg] || (pos_reg == 5'h1f);

    // walk positions in order; wrap to zero after the marked last slot
    always_comb begin
        pos_next = pos_reg;
        st_next = st_reg;
        case (st_reg)
            TDM_IDLE: begin
                st_next = TDM_SCAN;
                pos_next = 5'h00;
            end
            TDM_SCAN: begin
                if (take) begin
                    st_next = TDM_HOLD;
                end else begin
                    pos_next = is_last ? 5'h00 : pos_reg + 5'h01;
                end
            end
            TDM_HOLD: begin
                if (advance) begin
                    st_next = TDM_SCAN;
                    pos_next = is_last ? 5'h00 : pos_reg + 5'h01;
                end
            end
            default: st_next = TDM_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pos_reg <= 5'h00;
            st_reg <= TDM_IDLE;
            visit <= '0;
        end else if (clk_en) begin
            pos_reg <= pos_next;
            st_reg <= st_next;
            visit.valid <= (st_next == TDM_HOLD);
            visit.index <= pos_next;
            visit.wrap <= (st_reg != TDM_IDLE) && (pos_next == 5'h00) && (pos_reg != 5'h00);
        end
    end

    // a skipped slot must be passed over, never entered into hold
    a_scan_no_skip: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && st_reg == TDM_SCAN && skip_map[pos_reg] |=> st_reg != TDM_HOLD)
        else $error("skipped descriptor was taken");
    a_scan_wraps: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && st_reg == TDM_SCAN && !take && last_map[pos_reg] |=> pos_reg == 5'h00)
        else $error("scan did not restart after last slot");
endmodule
`default_nettype wire

// *** tdm_regs.sv ***
// register bank top: done, skip and last maps, scan order and connect status
// Functional notes
// - port status bit 0 reads 1 while a device is attached with port power on, and 0 otherwise.
// - connect status reads 0 whenever port power is off.
// - a 32-bit isochronous done map at 0x130 sets a bit on completion and resets to zero.
// - reading a done map returns its flags and clears every set bit.
// - a 32-bit interrupt done map at 0x140 behaves the same and resets to zero.
// - a read/write isochronous skip map at 0x134 resets to all ones.
// - a descriptor whose skip bit is set is bypassed even when valid.
// - the next pointer of a skipped descriptor never alters the scan order.
// - a read/write last-position map at 0x138 resets to zero.
// - the slot with its last bit set is the final one checked in a pass.
// - after the last slot the scan restarts at the first slot.
`timescale 1ns/1ps
`default_nettype none
module tdm_regs
    import tdm_pkg::*;
#(
    parameter int NUM = 32
) (
    // clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // processor bus
    input wire tdm_bus_req_t bus_req,
    output logic [31:0] rdata,
    output logic rvalid,
    // port state
    input wire logic device_attached,
    input wire logic port_power,
    output logic connect_status,
    // descriptor engine
    input wire logic [NUM-1:0] iso_complete,
    input wire logic [NUM-1:0] int_complete,
    input wire logic [NUM-1:0] iso_valid_map,
    input wire logic iso_advance,
    output var tdm_visit_t iso_visit
);
    logic [31:0] skip_reg;
    logic [31:0] skip_next;
    logic [31:0] last_reg;
    logic [31:0] last_next;
    logic [31:0] rdata_next;
    logic ccs_reg;
    logic ccs_next;
    logic [NUM-1:0] iso_done;
    logic [NUM-1:0] int_done;
    logic iso_rd;
    logic int_rd;
    logic rd_hit;
    tdm_visit_t visit_w;

    initial begin
        if (NUM != TDM_NUM_DESC) $error("tdm_regs: NUM must be 32");
    end

    // strobe for one register
    function automatic logic hit(input tdm_bus_req_t r, input logic [11:0] ofs);
        hit = r.cs && r.addr == ofs;
    endfunction

    // read of a done map is a clear only when the clock is enabled
    assign iso_rd = hit(bus_req, TDM_ISO_DONE_OFS) && bus_req.rd;
    assign int_rd = hit(bus_req, TDM_INT_DONE_OFS) && bus_req.rd;

    tdm_done_map #(.WIDTH(NUM)) u_iso_done (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .complete(iso_complete),
        .read_clear(iso_rd),
        .map(iso_done)
    );

    tdm_done_map #(.WIDTH(NUM)) u_int_done (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .complete(int_complete),
        .read_clear(int_rd),
        .map(int_done)
    );

    tdm_scan #(.NUM(NUM)) u_scan (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .skip_map(skip_reg[NUM-1:0]),
        .last_map(last_reg[NUM-1:0]),
        .valid_map(iso_valid_map),
        .advance(iso_advance),
        .visit(visit_w)
    );

    // writable maps
    always_comb begin
        skip_next = skip_reg;
        last_next = last_reg;
        if (bus_req.wr && hit(bus_req, TDM_ISO_SKIP_OFS)) begin
            skip_next = bus_req.wdata;
        end else if (bus_req.wr && hit(bus_req, TDM_ISO_LAST_OFS)) begin
            last_next = bus_req.wdata;
        end
    end

    // connect status gated by port power
    always_comb begin
        ccs_next = port_power && device_attached;
    end

    // read mux; done maps return the value before clearing
    always_comb begin
        rdata_next = 32'h0000_0000;
        rd_hit = bus_req.cs && bus_req.rd;
        if (hit(bus_req, TDM_ISO_DONE_OFS)) begin
            rdata_next = iso_done;
        end else if (hit(bus_req, TDM_ISO_SKIP_OFS)) begin
            rdata_next = skip_reg;
        end else if (hit(bus_req, TDM_ISO_LAST_OFS)) begin
            rdata_next = last_reg;
        end else if (hit(bus_req, TDM_INT_DONE_OFS)) begin
            rdata_next = int_done;
        end
        if (!rd_hit) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // register stage; all outputs straight from flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            skip_reg <= TDM_SKIP_RST;
            last_reg <= TDM_LAST_RST;
            ccs_reg <= 1'b0;
            rdata <= 32'h0000_0000;
            rvalid <= 1'b0;
        end else if (clk_en) begin
            skip_reg <= skip_next;
            last_reg <= last_next;
            ccs_reg <= ccs_next;
            rdata <= rdata_next;
            rvalid <= rd_hit;
        end
    end

    assign connect_status = ccs_reg;
    assign iso_visit = visit_w;

    a_ccs_power_off: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !port_power |=> !connect_status)
        else $error("connect status set without port power");
    a_ccs_follows: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && port_power && device_attached |=> connect_status)
        else $error("connect status missing with device attached");
    a_iso_read_value: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && iso_rd |=> rvalid && rdata == $past(iso_done))
        else $error("iso done read returned wrong value");
    a_int_read_value: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && int_rd |=> rvalid && rdata == $past(int_done))
        else $error("int done read returned wrong value");
    a_skip_write: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && bus_req.wr && hit(bus_req, TDM_ISO_SKIP_OFS) |=> skip_reg == $past(bus_req.wdata))
        else $error("skip map write lost");
    a_last_write: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && bus_req.wr && hit(bus_req, TDM_ISO_LAST_OFS) |=> last_reg == $past(bus_req.wdata))
        else $error("last map write lost");
    a_skip_reset: assert property (@(posedge clock)
        !rst_n |=> skip_reg == TDM_SKIP_RST)
        else $error("skip map reset value wrong");
    a_done_reset: assert property (@(posedge clock)
        !rst_n |=> iso_done == '0 && int_done == '0)
        else $error("done maps not zero after reset");
endmodule
`default_nettype wire

// *** tdm_host_model.sv ***
// host processor model driving the register bus of the descriptor maps
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model
    import tdm_pkg::*;
(
    // clock
    input wire logic clock,
    // processor bus
    output var tdm_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic rvalid
);
    initial bus_req = '0;

    // one write per cycle, changed only at falling edges
    task automatic write_word(input logic [11:0] addr, input logic [31:0] data);
        @(negedge clock);
        bus_req = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clock);
        bus_req = '0;
    endtask

    // the answer stands for the one cycle after the read edge
    task automatic read_word(input logic [11:0] addr, output logic [31:0] data,
                             output logic ok);
        @(negedge clock);
        bus_req = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0000_0000};
        @(negedge clock);
        bus_req = '0;
        data = rdata;
        ok = rvalid;
    endtask
endmodule
`default_nettype wire

// *** transfer_descriptor_maps_tb.sv ***
// self-checking bench for the transfer descriptor map register bank
`timescale 1ns/1ps
`default_nettype none
module transfer_descriptor_maps_tb;
    import tdm_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    tdm_bus_req_t bus_req;
    logic [31:0] rdata;
    logic rvalid;
    logic device_attached = 1'b0;
    logic port_power = 1'b0;
    logic connect_status;
    logic [31:0] iso_complete = 32'h0000_0000;
    logic [31:0] int_complete = 32'h0000_0000;
    logic [31:0] iso_valid_map = 32'h0000_0000;
    logic iso_advance = 1'b0;
    tdm_visit_t iso_visit;
    int err_total = 0;
    int checks = 0;

    // 200 MHz clock
    always #2.5 clock = ~clock;

    tdm_regs #(.NUM(32)) dut_u (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
        .rdata(rdata), .rvalid(rvalid), .device_attached(device_attached),
        .port_power(port_power), .connect_status(connect_status),
        .iso_complete(iso_complete), .int_complete(int_complete),
        .iso_valid_map(iso_valid_map), .iso_advance(iso_advance), .iso_visit(iso_visit)
    );

    tdm_host_model host_u (.clock(clock), .bus_req(bus_req), .rdata(rdata), .rvalid(rvalid));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // read one word and compare both the answer strobe and the data
    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string name);
        logic [31:0] d;
        logic ok;
        host_u.read_word(addr, d, ok);
        check({name, " rvalid"}, {31'h0, ok}, 32'h0000_0001);
        check(name, d, exp);
    endtask

    // completion pulses last exactly one clock
    task automatic pulse_done(input logic [31:0] iso, input logic [31:0] intr);
        @(negedge clock);
        iso_complete = iso;
        int_complete = intr;
        @(negedge clock);
        iso_complete = 32'h0000_0000;
        int_complete = 32'h0000_0000;
    endtask

    // engine side: wait for the presented slot, check it, then release it
    task automatic visit_chk(input logic [4:0] idx);
        int n;
        for (n = 0; n < 80; n++) begin
            @(negedge clock);
            if (iso_visit.valid === 1'b1) break;
        end
        check("visit valid", {31'h0, iso_visit.valid}, 32'h0000_0001);
        check("visit index", {27'h0, iso_visit.index}, {27'h0, idx});
        iso_advance = 1'b1;
        @(negedge clock);
        iso_advance = 1'b0;
        @(negedge clock);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // cut a hang short well beyond the fewer than a hundred cycles the tests need
    initial begin
        #(5 * 20000);
        err_total++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        logic ok;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        // reset values and an unmapped word
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0000, "iso done reset");
        rd_chk(TDM_ISO_SKIP_OFS, 32'hffff_ffff, "iso skip reset");
        rd_chk(TDM_ISO_LAST_OFS, 32'h0000_0000, "iso last reset");
        rd_chk(TDM_INT_DONE_OFS, 32'h0000_0000, "int done reset");
        rd_chk(12'h13c, 32'h0000_0000, "unmapped read");
        $display("test reset values done");
        // writable maps read back; done map ignores writes
        host_u.write_word(TDM_ISO_SKIP_OFS, 32'h0000_0002);
        host_u.write_word(TDM_ISO_LAST_OFS, 32'h0000_0004);
        host_u.write_word(TDM_ISO_DONE_OFS, 32'hffff_ffff);
        rd_chk(TDM_ISO_SKIP_OFS, 32'h0000_0002, "iso skip rw");
        rd_chk(TDM_ISO_LAST_OFS, 32'h0000_0004, "iso last rw");
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0000, "iso done write");
        $display("test register access done");
        // done flags set on completion and clear on read
        pulse_done(32'h0000_0008, 32'h8000_0001);
        pulse_done(32'h0000_0100, 32'h0000_0000);
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0108, "iso done set");
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0000, "iso done clear");
        rd_chk(TDM_INT_DONE_OFS, 32'h8000_0001, "int done set");
        rd_chk(TDM_INT_DONE_OFS, 32'h0000_0000, "int done clear");
        // completion in the very cycle of the read is kept
        pulse_done(32'h0000_0001, 32'h0000_0000);
        fork
            rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0001, "iso done race read");
            pulse_done(32'h0000_0020, 32'h0000_0000);
        join
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0020, "iso done survivor");
        // clock enable low: a read must not clear and a write must not land
        pulse_done(32'h0000_0004, 32'h0000_0000);
        clk_en = 1'b0;
        host_u.write_word(TDM_ISO_SKIP_OFS, 32'h0000_0000);
        host_u.read_word(TDM_ISO_DONE_OFS, d, ok);
        check("frozen rvalid", {31'h0, ok}, 32'h0000_0000);
        check("frozen rdata", d, 32'h0000_0000);
        clk_en = 1'b1;
        rd_chk(TDM_ISO_DONE_OFS, 32'h0000_0004, "iso done frozen");
        rd_chk(TDM_ISO_SKIP_OFS, 32'h0000_0002, "iso skip frozen");
        $display("test done maps done");
        // connect status follows attach, forced low without port power
        for (int k = 0; k < 4; k++) begin
            @(negedge clock);
            port_power = k[1];
            device_attached = k[0];
            @(negedge clock);
            check("connect status", {31'h0, connect_status}, {31'h0, k[1] & k[0]});
        end
        $display("test connect status done");
        // scan: slot 1 skipped, slot 2 marked last, all slots valid
        // start the slots only as the scan restarts, so slot 0 comes first
        for (int w = 0; w < 80 && iso_visit.wrap !== 1'b1; w++) @(negedge clock);
        check("scan wrap", {31'h0, iso_visit.wrap}, 32'h0000_0001);
        iso_valid_map = 32'hffff_ffff;
        visit_chk(5'd0);
        visit_chk(5'd2);
        visit_chk(5'd0);
        visit_chk(5'd2);
        iso_valid_map = 32'h0000_0000;
        $display("test scan order done");
        report_and_stop();
    end
endmodule
`default_nettype wire
